// ==== gpio_ports_regs.svh ====
// Register offsets, field positions, reset values and sync depth for the GPIO ports.
// Assumes an 8-bit register file reached by a core-side address with a bank number.
`ifndef GPIO_PORTS_REGS_SVH
`define GPIO_PORTS_REGS_SVH

`define PULLUP_CONTROL_OFS   8'h10
`define FIRST_DIR_OFS        8'h11
`define FIRST_DATA_OFS       8'h12
`define PERIPH_FLAGS_OFS     8'h16
`define PERIPH_ENABLES_OFS   8'h17
`define SECOND_DIR_OFS       8'h10
`define SECOND_DATA_OFS      8'h11
`define BANK_ZERO            4'h0
`define BANK_ONE             4'h1
`define PULLUP_N_BIT         7
`define CHANGE_FLAG_BIT      7
`define DIR_RESET            8'hFF
`define FLAGS_RESET          8'h02
`define ENABLES_RESET        8'h00
`define SYNC_STAGES          2

`endif

// ==== gpio_ports_pkg.sv ====
// Types shared by the GPIO port files.
// Assumes nothing of its surroundings.
package gpio_ports_pkg;
	typedef enum logic [1:0] {
		MODE_MICROPROCESSOR,
		MODE_EXTENDED,
		MODE_MICROCONTROLLER,
		MODE_PROTECTED
	} proc_mode_t;

	typedef enum logic [1:0] {
		REG_NONE,
		REG_FIRST,
		REG_SECOND,
		REG_CONTROL
	} reg_group_t;
endpackage : gpio_ports_pkg

// ==== pin_sync.sv ====
// Two-stage synchroniser for a bank of pin inputs.
// Assumes the pins are asynchronous to ref_clk.
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin_async,
	output logic      [WIDTH-1:0] pin_sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second one.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg     <= '0;
			pin_sync_out <= '0;
		end else begin
			meta_reg     <= pin_async;
			pin_sync_out <= meta_reg;
		end
	end
endmodule : pin_sync

// ==== port_pin_bank.sv ====
// One 8-bit bidirectional port: direction, latch, synchronised pin read.
// Assumes the core writes its registers with one-cycle strobes.
`include "gpio_ports_regs.svh"
module port_pin_bank
	import gpio_ports_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             dir_wr,
	input  wire logic             data_wr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] direction_reg,
	output logic      [WIDTH-1:0] latch_reg,
	output logic      [WIDTH-1:0] pin_level
);
	// Direction resets to all inputs so nothing is driven before software decides.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			direction_reg <= WIDTH'(`DIR_RESET);
		end else if (dir_wr) begin
			direction_reg <= wr_data;
		end
	end

	// The latch takes writes only; reads come from the pins.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_reg <= '0;
		end else if (data_wr) begin
			latch_reg <= wr_data;
		end
	end

	pin_sync #(.WIDTH(WIDTH)) u_sync (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.pin_async    (pin_in),
		.pin_sync_out (pin_level)
	);
endmodule : port_pin_bank

// ==== pin_change_gpio_ports.sv ====
// Two general purpose ports: pull-ups and change detect on the first, bus handover on the second.
// Assumes a core register port with bank select; pads resolve in/out/enable.
`include "gpio_ports_regs.svh"
module pin_change_gpio_ports
	import gpio_ports_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [3:0]       bank_selector,
	input  wire logic [7:0]       reg_addr,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	input  wire logic [7:0]       reg_wdata,
	output logic      [7:0]       reg_rdata,
	input  wire logic [1:0]       proc_mode,
	input  wire logic             sleep_active,
	output logic                  wake_request,
	output logic                  pin_change_irq,
	input  wire logic [6:0]       other_flags_in,
	input  wire logic [WIDTH-1:0] first_pin_in,
	output logic      [WIDTH-1:0] first_pin_out,
	output logic      [WIDTH-1:0] first_pin_oe,
	output logic      [WIDTH-1:0] first_pullup_on,
	input  wire logic [WIDTH-1:0] second_pin_in,
	output logic      [WIDTH-1:0] second_pin_out,
	output logic      [WIDTH-1:0] second_pin_oe,
	input  wire logic             bus_active,
	input  wire logic             bus_drive,
	input  wire logic [7:0]       bus_low_byte_out,
	output logic      [7:0]       bus_low_byte_in,
	input  wire logic             pulse_one_on,
	input  wire logic             pulse_two_on,
	input  wire logic             serial_on,
	input  wire logic             pulse_out_one,
	input  wire logic             pulse_out_two,
	input  wire logic             serial_clock_out,
	input  wire logic             serial_clock_drive,
	input  wire logic             serial_data_out,
	output logic                  capture_in_one,
	output logic                  capture_in_two,
	output logic                  timer_one_two_ext_clock,
	output logic                  timer_three_ext_clock,
	output logic                  serial_clock_in
);
	logic             pullup_enable_n_reg;
	logic [6:0]       flags_low_reg;
	logic             pin_change_flag_reg;
	logic [7:0]       enables_reg;
	logic [WIDTH-1:0] first_dir;
	logic [WIDTH-1:0] first_latch;
	logic [WIDTH-1:0] first_level;
	logic [WIDTH-1:0] second_dir;
	logic [WIDTH-1:0] second_latch;
	logic [WIDTH-1:0] second_level;
	logic [WIDTH-1:0] mismatch;
	logic             any_mismatch;
	logic             bus_mode;
	logic [WIDTH-1:0] periph_own;
	logic [WIDTH-1:0] periph_val;
	logic [7:0]       reg_rdata_next;
	reg_group_t       wr_group;

	// Bank-aware decode used for both reads and writes.
	function automatic logic hit(input logic [3:0] bank, input logic [7:0] addr,
		input logic [3:0] want_bank, input logic [7:0] want_addr);
		hit = (bank == want_bank) && (addr == want_addr);
	endfunction : hit

	// The first port data address is unbanked.
	logic wr_first_dir;
	logic wr_first_data;
	logic wr_second_dir;
	logic wr_second_data;
	logic wr_pullup;
	logic wr_flags;
	logic wr_enables;

	assign wr_first_dir   = reg_wr && hit(bank_selector, reg_addr, `BANK_ZERO, `FIRST_DIR_OFS);
	assign wr_first_data  = reg_wr && (reg_addr == `FIRST_DATA_OFS);
	assign wr_second_dir  = reg_wr && hit(bank_selector, reg_addr, `BANK_ONE, `SECOND_DIR_OFS);
	assign wr_second_data = reg_wr && hit(bank_selector, reg_addr, `BANK_ONE, `SECOND_DATA_OFS);
	assign wr_pullup      = reg_wr && hit(bank_selector, reg_addr, `BANK_ZERO, `PULLUP_CONTROL_OFS);
	assign wr_flags       = reg_wr && hit(bank_selector, reg_addr, `BANK_ONE, `PERIPH_FLAGS_OFS);
	assign wr_enables     = reg_wr && hit(bank_selector, reg_addr, `BANK_ONE, `PERIPH_ENABLES_OFS);

	always_comb begin
		if (wr_first_dir || wr_first_data) begin
			wr_group = REG_FIRST;
		end else if (wr_second_dir || wr_second_data) begin
			wr_group = REG_SECOND;
		end else if (wr_pullup || wr_flags || wr_enables) begin
			wr_group = REG_CONTROL;
		end else begin
			wr_group = REG_NONE;
		end
	end

	port_pin_bank #(.WIDTH(WIDTH)) u_first (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.dir_wr        (wr_first_dir),
		.data_wr       (wr_first_data),
		.wr_data       (reg_wdata),
		.pin_in        (first_pin_in),
		.direction_reg (first_dir),
		.latch_reg     (first_latch),
		.pin_level     (first_level)
	);

	port_pin_bank #(.WIDTH(WIDTH)) u_second (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.dir_wr        (wr_second_dir),
		.data_wr       (wr_second_data),
		.wr_data       (reg_wdata),
		.pin_in        (second_pin_in),
		.direction_reg (second_dir),
		.latch_reg     (second_latch),
		.pin_level     (second_level)
	);

	// Reset always re-arms the pull-ups, whatever the reset source.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pullup_enable_n_reg <= 1'b0;
		end else if (wr_pullup) begin
			pullup_enable_n_reg <= reg_wdata[`PULLUP_N_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enables_reg <= `ENABLES_RESET;
		end else if (wr_enables) begin
			enables_reg <= reg_wdata;
		end
	end

	// Low flag bits belong to other peripherals; they are OR-set here and cleared by writes.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_low_reg <= 7'(`FLAGS_RESET);
		end else if (wr_flags) begin
			flags_low_reg <= reg_wdata[6:0] | other_flags_in;
		end else begin
			flags_low_reg <= flags_low_reg | other_flags_in;
		end
	end

	// Synchronised samples make the compare safe to run every cycle.
	assign mismatch     = first_dir & (first_level ^ first_latch);
	assign any_mismatch = |mismatch;

	// Set beats clear, so a persisting mismatch cannot be cleared away.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_change_flag_reg <= 1'b0;
		end else if (any_mismatch) begin
			pin_change_flag_reg <= 1'b1;
		end else if (wr_flags) begin
			pin_change_flag_reg <= reg_wdata[`CHANGE_FLAG_BIT];
		end
	end

	assign pin_change_irq = pin_change_flag_reg & enables_reg[`CHANGE_FLAG_BIT];
	assign wake_request   = sleep_active & pin_change_irq;

	// Pull-up only on input pins, and only while the shared control is low.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_pullup_on <= '0;
		end else begin
			first_pullup_on <= {WIDTH{~pullup_enable_n_reg}} & first_dir;
		end
	end

	// Peripheral ownership of first-port pins; direction bits are overridden.
	always_comb begin
		periph_own    = '0;
		periph_val    = '0;
		periph_own[2] = pulse_one_on;
		periph_val[2] = pulse_out_one;
		periph_own[3] = pulse_two_on;
		periph_val[3] = pulse_out_two;
		periph_own[6] = serial_on & serial_clock_drive;
		periph_val[6] = serial_clock_out;
		periph_own[7] = serial_on;
		periph_val[7] = serial_data_out;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_pin_out <= '0;
			first_pin_oe  <= '0;
		end else begin
			first_pin_oe  <= periph_own | ~first_dir;
			first_pin_out <= (periph_own & periph_val) | (~periph_own & first_latch);
		end
	end

	// Input functions read the synchronised pin level, even if the pin is an output.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_in_one          <= 1'b0;
			capture_in_two          <= 1'b0;
			timer_one_two_ext_clock <= 1'b0;
			timer_three_ext_clock   <= 1'b0;
			serial_clock_in         <= 1'b0;
		end else begin
			capture_in_one          <= first_level[0];
			capture_in_two          <= first_level[1];
			timer_one_two_ext_clock <= first_level[4];
			timer_three_ext_clock   <= first_level[5];
			serial_clock_in         <= first_level[6];
		end
	end

	assign bus_mode = (proc_mode == MODE_MICROPROCESSOR) || (proc_mode == MODE_EXTENDED);

	// The external bus controller owns the second port in the two bus modes.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			second_pin_out <= '0;
			second_pin_oe  <= '0;
		end else if (bus_mode) begin
			second_pin_out <= bus_low_byte_out;
			second_pin_oe  <= {WIDTH{bus_active & bus_drive}};
		end else begin
			second_pin_out <= second_latch;
			second_pin_oe  <= ~second_dir;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_low_byte_in <= '0;
		end else begin
			bus_low_byte_in <= second_level;
		end
	end

	// Read mux; unmapped addresses read zero. Reserved pull-up bits read zero too.
	always_comb begin
		reg_rdata_next = 8'h00;
		if (reg_addr == `FIRST_DATA_OFS) begin
			reg_rdata_next = first_level;
		end else if (hit(bank_selector, reg_addr, `BANK_ZERO, `PULLUP_CONTROL_OFS)) begin
			reg_rdata_next = {pullup_enable_n_reg, 7'h00};
		end else if (hit(bank_selector, reg_addr, `BANK_ZERO, `FIRST_DIR_OFS)) begin
			reg_rdata_next = first_dir;
		end else if (hit(bank_selector, reg_addr, `BANK_ONE, `SECOND_DIR_OFS)) begin
			reg_rdata_next = second_dir;
		end else if (hit(bank_selector, reg_addr, `BANK_ONE, `SECOND_DATA_OFS)) begin
			reg_rdata_next = second_level;
		end else if (hit(bank_selector, reg_addr, `BANK_ONE, `PERIPH_FLAGS_OFS)) begin
			reg_rdata_next = {pin_change_flag_reg, flags_low_reg};
		end else if (hit(bank_selector, reg_addr, `BANK_ONE, `PERIPH_ENABLES_OFS)) begin
			reg_rdata_next = enables_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= reg_rdata_next;
		end
	end

	sequence mismatch_seen;
		any_mismatch;
	endsequence

	chk_flag_sets_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mismatch_seen |=> pin_change_flag_reg)
		else $error("change flag not set after mismatch");
	chk_clear_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(any_mismatch && wr_flags && !reg_wdata[7]) |=> pin_change_flag_reg)
		else $error("flag cleared while mismatch persisted");
	chk_output_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(first_dir == '0) |-> !any_mismatch)
		else $error("output pins raised a mismatch");
	chk_pullup_gating: assert property (@(posedge ref_clk) disable iff (!rst_n)
		##1 ((first_pullup_on & ~$past(first_dir)) == '0))
		else $error("pull-up on an output pin");
	chk_pullup_shared: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pullup_enable_n_reg |=> (first_pullup_on == '0))
		else $error("pull-ups on while control bit set");
	// The release edge itself is left out: the output flops were still in reset there.
	chk_drive_dir: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && (periph_own == '0)) |=> (first_pin_oe == ~$past(first_dir)))
		else $error("first port enable differs from direction");
	chk_latch_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_first_data |=> (first_latch == $past(reg_wdata)))
		else $error("latch not written");
	chk_bus_takeover: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && bus_mode) |=> (second_pin_out == $past(bus_low_byte_out)))
		else $error("second port not handed to bus");
	chk_wake_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sleep_active && pin_change_flag_reg && enables_reg[7]) |-> wake_request)
		else $error("no wake on pending change");
	chk_gpio_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rst_n && !bus_mode) |=> (second_pin_oe == ~$past(second_dir)))
		else $error("second port not plain I/O");
endmodule : pin_change_gpio_ports

// ==== pin_pad_model.sv ====
// Pad and board model for one 8-bit port: resolves the design drive, an outside driver and pull-ups.
// Assumes the bench never lets an outside driver and the design drive one pin together.
module pin_pad_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pad_pullup,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	output logic      [7:0] pad_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] float_pat = 8'h00;

	// A floating pin flips every cycle so a missing pull-up never reads as a steady level.
	always_ff @(posedge ref_clk) begin
		float_pat <= ~float_pat;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i]) pad_level[i] = pad_out[i];
			else if (ext_en[i]) pad_level[i] = ext_val[i];
			else if (pad_pullup[i]) pad_level[i] = 1'b1;
			else pad_level[i] = float_pat[i];
		end
	end
endmodule : pin_pad_model

// ==== test_pin_change_gpio_ports.sv ====
// Self-checking bench for the two GPIO ports, driving the core register side and the pads.
// Assumes the design modules and the pad model are compiled before this file.
module test_pin_change_gpio_ports;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sleep_active = 1'b0;
	logic [3:0] bank_selector = 4'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
	logic [1:0] proc_mode = 2'h2;
	logic wake_request, pin_change_irq, bus_active = 1'b0, bus_drive = 1'b0;
	logic [6:0] other_flags_in = 7'h00;
	logic [7:0] first_pin_in, first_pin_out, first_pin_oe, first_pullup_on;
	logic [7:0] second_pin_in, second_pin_out, second_pin_oe, bus_low_byte_in;
	logic [7:0] bus_low_byte_out = 8'h00, ext1_val = 8'h00, ext1_en = 8'h00;
	logic [7:0] ext2_val = 8'h00, ext2_en = 8'h00;
	logic pulse_one_on = 1'b0, pulse_two_on = 1'b0, serial_on = 1'b0, pulse_out_one = 1'b0;
	logic pulse_out_two = 1'b0, serial_clock_out = 1'b0, serial_clock_drive = 1'b0;
	logic serial_data_out = 1'b0;
	logic capture_in_one, capture_in_two, timer_one_two_ext_clock, timer_three_ext_clock;
	logic serial_clock_in;
	int bad_count = 0, compares = 0, cycles = 0;

	always #20 ref_clk = ~ref_clk;

	pin_change_gpio_ports i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.bank_selector(bank_selector), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .proc_mode(proc_mode),
		.sleep_active(sleep_active), .wake_request(wake_request),
		.pin_change_irq(pin_change_irq), .other_flags_in(other_flags_in),
		.first_pin_in(first_pin_in), .first_pin_out(first_pin_out),
		.first_pin_oe(first_pin_oe), .first_pullup_on(first_pullup_on),
		.second_pin_in(second_pin_in), .second_pin_out(second_pin_out),
		.second_pin_oe(second_pin_oe), .bus_active(bus_active), .bus_drive(bus_drive),
		.bus_low_byte_out(bus_low_byte_out), .bus_low_byte_in(bus_low_byte_in),
		.pulse_one_on(pulse_one_on), .pulse_two_on(pulse_two_on), .serial_on(serial_on),
		.pulse_out_one(pulse_out_one), .pulse_out_two(pulse_out_two),
		.serial_clock_out(serial_clock_out), .serial_clock_drive(serial_clock_drive),
		.serial_data_out(serial_data_out), .capture_in_one(capture_in_one),
		.capture_in_two(capture_in_two), .timer_one_two_ext_clock(timer_one_two_ext_clock),
		.timer_three_ext_clock(timer_three_ext_clock), .serial_clock_in(serial_clock_in));

	pin_pad_model i_first_pads (.ref_clk(ref_clk), .pad_out(first_pin_out),
		.pad_oe(first_pin_oe), .pad_pullup(first_pullup_on), .ext_val(ext1_val),
		.ext_en(ext1_en), .pad_level(first_pin_in));
	// The second port has no pull-ups, so undriven pins float.
	pin_pad_model i_second_pads (.ref_clk(ref_clk), .pad_out(second_pin_out),
		.pad_oe(second_pin_oe), .pad_pullup(8'h00), .ext_val(ext2_val),
		.ext_en(ext2_en), .pad_level(second_pin_in));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bank_selector <= b;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] b, input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bank_selector <= b;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// Four edges cover the write-to-pin and pin-to-flag latencies of the design.
	task automatic settle();
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic test_reset();
		settle();
		check(first_pullup_on, 8'hFF);
		rd(4'h0, 8'h11, v); check(v, 8'hFF);
		// Pulled-up inputs against the cleared latch already raise the change flag.
		rd(4'h1, 8'h16, v); check(v, 8'h82);
		rd(4'h1, 8'h17, v); check(v, 8'h00);
		rd(4'h0, 8'h12, v); check(v, 8'hFF);
		rd(4'h0, 8'h20, v); check(v, 8'h00);
		$display("test_reset done");
	endtask : test_reset

	task automatic test_direction();
		ext1_en <= 8'hF0;
		ext1_val <= 8'hA0;
		wr(4'h0, 8'h12, 8'h55);
		wr(4'h0, 8'h11, 8'hF0);
		settle();
		check(first_pin_oe, 8'h0F);
		check(first_pin_out & 8'h0F, 8'h05);
		check(first_pullup_on, 8'hF0);
		rd(4'h0, 8'h12, v); check(v, 8'hA5);
		wr(4'h0, 8'h10, 8'h80);
		settle();
		check(first_pullup_on, 8'h00);
		wr(4'h0, 8'h10, 8'h00);
		settle();
		check(first_pullup_on, 8'hF0);
		$display("test_direction done");
	endtask : test_direction

	task automatic test_change();
		wr(4'h1, 8'h17, 8'h80);
		settle();
		check({7'h00, pin_change_irq}, 8'h01);
		wr(4'h1, 8'h16, 8'h00);
		settle();
		rd(4'h1, 8'h16, v); check(v, 8'h80);
		@(posedge ref_clk);
		sleep_active <= 1'b1;
		settle();
		check({7'h00, wake_request}, 8'h01);
		rd(4'h0, 8'h12, v);
		wr(4'h0, 8'h12, v);
		settle();
		wr(4'h1, 8'h16, 8'h00);
		settle();
		rd(4'h1, 8'h16, v); check(v, 8'h00);
		check({6'h00, pin_change_irq, wake_request}, 8'h00);
		wr(4'h0, 8'h12, 8'hA4);
		settle();
		check({7'h00, pin_change_irq}, 8'h00);
		ext1_val <= 8'hB0;
		settle();
		check({7'h00, pin_change_irq}, 8'h01);
		ext1_val <= 8'hA0;
		settle();
		wr(4'h1, 8'h16, 8'h00);
		sleep_active <= 1'b0;
		$display("test_change done");
	endtask : test_change

	task automatic test_peripherals();
		wr(4'h0, 8'h11, 8'hFF);
		ext1_en <= 8'h33;
		ext1_val <= 8'h31;
		pulse_one_on <= 1'b1;
		pulse_out_one <= 1'b1;
		serial_on <= 1'b1;
		serial_data_out <= 1'b1;
		pulse_two_on <= 1'b1;
		serial_clock_drive <= 1'b1;
		serial_clock_out <= 1'b1;
		settle();
		check(first_pin_oe, 8'hCC);
		check(first_pin_out & 8'hCC, 8'hC4);
		check({6'h00, capture_in_two, capture_in_one}, 8'h01);
		check({6'h00, timer_three_ext_clock, timer_one_two_ext_clock}, 8'h03);
		check({7'h00, serial_clock_in}, 8'h01);
		$display("test_peripherals done");
	endtask : test_peripherals

	task automatic test_second();
		wr(4'h1, 8'h11, 8'h3C);
		wr(4'h1, 8'h10, 8'h0F);
		bus_active <= 1'b1;
		bus_drive <= 1'b1;
		bus_low_byte_out <= 8'h96;
		ext2_val <= 8'h09;
		for (int m = 0; m < 4; m++) begin
			@(posedge ref_clk);
			proc_mode <= 2'(m);
			ext2_en <= (m < 2) ? 8'h00 : 8'h0F;
			settle();
			if (m < 2) begin
				check(second_pin_oe, 8'hFF);
				check(second_pin_out, 8'h96);
			end else begin
				check(second_pin_oe, 8'hF0);
				check(second_pin_out & 8'hF0, 8'h30);
				rd(4'h1, 8'h11, v); check(v, 8'h39);
			end
		end
		@(posedge ref_clk);
		proc_mode <= 2'h0;
		bus_drive <= 1'b0;
		ext2_en <= 8'hFF;
		ext2_val <= 8'h5A;
		settle();
		check(second_pin_oe, 8'h00);
		check(bus_low_byte_in, 8'h5A);
		$display("test_second done");
	endtask : test_second

	// A reset in mid-run must bring the pull-ups and directions back.
	task automatic test_mid_reset();
		ext1_en <= 8'h00;
		wr(4'h0, 8'h10, 8'h80);
		wr(4'h0, 8'h11, 8'h00);
		settle();
		check(first_pullup_on, 8'h00);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		settle();
		check(first_pullup_on, 8'hFF);
		rd(4'h0, 8'h10, v); check(v, 8'h00);
		rd(4'h0, 8'h11, v); check(v, 8'hFF);
		$display("test_mid_reset done");
	endtask : test_mid_reset

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	// The tests need well under a thousand cycles; the ceiling leaves ample margin.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			$display("unexpected at %0t: run did not finish", $time);
			final_report();
		end
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		test_reset();
		test_direction();
		test_change();
		test_peripherals();
		test_second();
		test_mid_reset();
		final_report();
	end
endmodule : test_pin_change_gpio_ports
